// ===== core/switch_led_pkg.sv
// Constants for the user switch, indicator and pushbutton register block.
// Assumes a 32-bit APB slave with byte addresses.
package switch_led_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int LED_W = 8;
    localparam int SW_W = 8;

    localparam logic [ADDR_W-1:0] USER_INDICATOR_CONTROL_ADDR = 32'h0100_0008;
    localparam logic [ADDR_W-1:0] MISC_SYSTEM_CONTROL_ADDR = 32'h0100_0060;
    localparam logic [ADDR_W-1:0] USER_SWITCH_STATE_ADDR = 32'h1000_0004;
    localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = 32'h0100_0070;
    localparam logic [ADDR_W-1:0] IRQ_CLEAR_ADDR = 32'h0100_0074;
    localparam logic [ADDR_W-1:0] IRQ_ENABLE_ADDR = 32'h0100_0078;

    localparam int MISC_PRESS_IRQ_EN_BIT = 3;
    localparam int MISC_BUTTON_BIT = 4;
    localparam int IRQ_POWER_FAIL_BIT = 0;
    localparam int IRQ_W = 1;

    localparam logic [LED_W-1:0] LED_RESET = 8'h00;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 1'h0;
    localparam logic PRESS_IRQ_EN_RESET = 1'b0;
    localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;
endpackage

// ===== core/button_press_detect.sv
// Registers the pushbutton level and marks each new press.
// Assumes the button input is synchronous to pclk, high while pressed.
`timescale 1ns/1ps
`default_nettype none
module button_press_detect (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic button,
    output logic level,
    output logic press
);
    logic next_level;

    always_comb begin
        next_level = button;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level <= 1'b0;
        end else begin
            level <= next_level;
        end
    end

    // Rising edge of the button input, seen against its registered level
    assign press = button & ~level;
endmodule
`default_nettype wire

// ===== core/switch_led_regs.sv
// APB register block for user indicators, slide switches and pushbutton.
// Assumes a zero-wait APB master; switch and button inputs synchronous to pclk.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R1 - Indicator register bits 7..0 drive LEDs 7..0; a set bit lights its LED.
// R2 - Switch register bits 7..0 show slide switch positions 8..1.
// R3 - Misc register bit 4 shows the current pushbutton state.
// R4 - With misc bit 3 set, each button press raises the power-fail interrupt; here the output also needs IRQ enable bit 0 set.
// R5 - The power-fail interrupt is a level output usable for shutdown or wake.
// R6 - Switch register ignores writes; indicator register reads back last write.
module switch_led_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [switch_led_pkg::ADDR_W-1:0] paddr,
    input wire logic [switch_led_pkg::DATA_W-1:0] pwdata,
    output logic [switch_led_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [switch_led_pkg::LED_W-1:0] user_led,
    input wire logic [switch_led_pkg::SW_W-1:0] user_slide_switch_bank,
    input wire logic general_pushbutton,
    output logic power_fail_interrupt
);
    import switch_led_pkg::*;

    logic [LED_W-1:0] next_user_led;
    logic press_irq_en;
    logic next_press_irq_en;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] next_irq_status;
    logic [IRQ_W-1:0] irq_enable;
    logic [IRQ_W-1:0] next_irq_enable;
    logic [DATA_W-1:0] next_prdata;
    logic button_level;
    logic button_press;
    logic setup;
    logic wr_access;
    logic mapped;
    logic [IRQ_W-1:0] irq_event;
    logic [IRQ_W-1:0] irq_clear;

    ////////////////////////////////////////////////////////////////////////////
    // Pushbutton level and press detection

    button_press_detect u_press (
        .pclk(pclk),
        .presetn(presetn),
        .button(general_pushbutton),
        .level(button_level),
        .press(button_press)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode

    assign setup = psel & ~penable;
    assign wr_access = psel & penable & pwrite;
    assign pready = 1'b1;

    always_comb begin
        case (paddr)
            USER_INDICATOR_CONTROL_ADDR, MISC_SYSTEM_CONTROL_ADDR,
            USER_SWITCH_STATE_ADDR, IRQ_STATUS_ADDR,
            IRQ_CLEAR_ADDR, IRQ_ENABLE_ADDR: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    assign pslverr = psel & penable & ~mapped;

    ////////////////////////////////////////////////////////////////////////////
    // Control registers

    always_comb begin
        next_user_led = user_led;
        next_press_irq_en = press_irq_en;
        next_irq_enable = irq_enable;
        irq_clear = '0;
        if (wr_access) begin
            case (paddr)
                USER_INDICATOR_CONTROL_ADDR: begin
                    next_user_led = pwdata[LED_W-1:0]; // R1
                end
                MISC_SYSTEM_CONTROL_ADDR: begin
                    next_press_irq_en = pwdata[MISC_PRESS_IRQ_EN_BIT];
                end
                IRQ_ENABLE_ADDR: begin
                    next_irq_enable = pwdata[IRQ_W-1:0];
                end
                IRQ_CLEAR_ADDR: begin
                    irq_clear = pwdata[IRQ_W-1:0];
                end
                default: begin
                    next_user_led = user_led; // R6
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            user_led <= LED_RESET;
            press_irq_en <= PRESS_IRQ_EN_RESET;
            irq_enable <= IRQ_RESET;
        end else begin
            user_led <= next_user_led;
            press_irq_en <= next_press_irq_en;
            irq_enable <= next_irq_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status, set wins over clear

    always_comb begin
        irq_event = '0;
        irq_event[IRQ_POWER_FAIL_BIT] = button_press & press_irq_en; // R4
        next_irq_status = (irq_status & ~irq_clear) | irq_event;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= IRQ_RESET;
        end else begin
            irq_status <= next_irq_status;
        end
    end

    assign power_fail_interrupt = |(irq_status & irq_enable); // R5

    ////////////////////////////////////////////////////////////////////////////
    // Read data, captured in the setup cycle

    always_comb begin
        next_prdata = prdata;
        if (setup) begin
            next_prdata = READ_ZERO;
            if (!pwrite) begin
                case (paddr)
                    USER_INDICATOR_CONTROL_ADDR: begin
                        next_prdata[LED_W-1:0] = user_led; // R6
                    end
                    USER_SWITCH_STATE_ADDR: begin
                        next_prdata[SW_W-1:0] = user_slide_switch_bank; // R2
                    end
                    MISC_SYSTEM_CONTROL_ADDR: begin
                        next_prdata[MISC_BUTTON_BIT] = button_level; // R3
                        next_prdata[MISC_PRESS_IRQ_EN_BIT] = press_irq_en;
                    end
                    IRQ_STATUS_ADDR: begin
                        next_prdata[IRQ_W-1:0] = irq_status;
                    end
                    IRQ_ENABLE_ADDR: begin
                        next_prdata[IRQ_W-1:0] = irq_enable;
                    end
                    default: begin
                        next_prdata = READ_ZERO;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= READ_ZERO;
        end else begin
            prdata <= next_prdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    property p_led_write;
        @(posedge pclk) disable iff (!presetn)
        (wr_access && paddr == USER_INDICATOR_CONTROL_ADDR)
            |=> user_led == $past(pwdata[LED_W-1:0]);
    endproperty
    a_led_write: assert property (p_led_write) else $error("led not updated"); // R1

    property p_switch_read;
        @(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && paddr == USER_SWITCH_STATE_ADDR)
            |=> prdata == {24'h00_0000, $past(user_slide_switch_bank)};
    endproperty
    a_switch_read: assert property (p_switch_read) else $error("switch read wrong"); // R2

    property p_button_read;
        @(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && paddr == MISC_SYSTEM_CONTROL_ADDR)
            |=> prdata[MISC_BUTTON_BIT] == $past(button_level);
    endproperty
    a_button_read: assert property (p_button_read) else $error("button read wrong"); // R3

    property p_press_irq;
        @(posedge pclk) disable iff (!presetn)
        (general_pushbutton && !button_level && press_irq_en)
            |=> irq_status[IRQ_POWER_FAIL_BIT] && button_level;
    endproperty
    a_press_irq: assert property (p_press_irq) else $error("press lost"); // R4

    property p_no_irq_disabled;
        @(posedge pclk) disable iff (!presetn)
        (!press_irq_en && !irq_status[IRQ_POWER_FAIL_BIT])
            |=> !irq_status[IRQ_POWER_FAIL_BIT];
    endproperty
    a_no_irq_disabled: assert property (p_no_irq_disabled) else $error("spurious irq"); // R4

    property p_irq_level;
        @(posedge pclk) disable iff (!presetn)
        (irq_status[IRQ_POWER_FAIL_BIT] && irq_enable[IRQ_POWER_FAIL_BIT] && !wr_access)
            |=> power_fail_interrupt;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq dropped"); // R5

    property p_switch_write_ignored;
        @(posedge pclk) disable iff (!presetn)
        (wr_access && paddr == USER_SWITCH_STATE_ADDR) |=> $stable(user_led) && !$past(pslverr);
    endproperty
    a_switch_write_ignored: assert property (p_switch_write_ignored) else $error("sw write"); // R6

    property p_led_readback;
        @(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && paddr == USER_INDICATOR_CONTROL_ADDR)
            |=> prdata[LED_W-1:0] == $past(user_led);
    endproperty
    a_led_readback: assert property (p_led_readback) else $error("led readback"); // R6

    c_press_irq: cover property (@(posedge pclk) disable iff (!presetn)
        power_fail_interrupt ##1 (wr_access && paddr == IRQ_CLEAR_ADDR));
    c_led_write: cover property (@(posedge pclk) disable iff (!presetn)
        wr_access && paddr == USER_INDICATOR_CONTROL_ADDR);
    c_unmapped: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
endmodule
`default_nettype wire

// ===== bench/user_panel.sv
// Model of the slide switches and pushbutton facing the register block.
// Assumes bench commands change right after a rising pclk edge.
`timescale 1ns/1ps
`default_nettype none
module user_panel (
    input wire logic pclk,
    input wire logic [switch_led_pkg::SW_W-1:0] sw_set,
    input wire logic btn_set,
    output logic [switch_led_pkg::SW_W-1:0] switches,
    output logic button
);
    import switch_led_pkg::*;

    // Contacts settled onto pclk, as the block expects synchronous levels
    always_ff @(posedge pclk) begin
        switches <= sw_set;
        button <= btn_set;
    end
endmodule
`default_nettype wire

// ===== bench/tb.sv
// Self-checking bench for the switch and indicator register block.
// Assumes a 100 MHz pclk and an APB master that waits for pready.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import switch_led_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, btn_set, button;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, r;
    logic [LED_W-1:0] user_led;
    logic [SW_W-1:0] sw_set, switches;
    logic e;
    int fail_count, checks;
    switch_led_regs switch_led_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .user_led(user_led),
        .user_slide_switch_bank(switches), .general_pushbutton(button),
        .power_fail_interrupt(irq));
    user_panel user_panel_i (.pclk(pclk), .sw_set(sw_set), .btn_set(btn_set),
        .switches(switches), .button(button));
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(r, exp);
    endtask
    task automatic wait3();
        repeat (3) @(posedge pclk);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        fail_count++;
        conclude();
    end
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, btn_set} = 4'h0;
        paddr = '0;
        pwdata = '0;
        sw_set = 8'h00;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check({24'h0, user_led}, 32'h0);
        check({31'h0, irq}, 32'h0);
        rd(USER_INDICATOR_CONTROL_ADDR, 32'h0);
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, USER_INDICATOR_CONTROL_ADDR, 32'h1 << i);
            check({24'h0, user_led}, 32'h1 << i);
        end
        apb(1'b1, USER_INDICATOR_CONTROL_ADDR, 32'hffff_ffa5);
        rd(USER_INDICATOR_CONTROL_ADDR, 32'h0000_00a5);
        sw_set <= 8'h3c;
        wait3();
        rd(USER_SWITCH_STATE_ADDR, 32'h0000_003c);
        check({31'h0, e}, 32'h0);
        apb(1'b1, USER_SWITCH_STATE_ADDR, 32'h0000_00ff);
        check({31'h0, e}, 32'h0);
        check({24'h0, user_led}, 32'h0000_00a5);
        sw_set <= 8'hc1;
        wait3();
        rd(USER_SWITCH_STATE_ADDR, 32'h0000_00c1);
        btn_set <= 1'b1;
        wait3();
        rd(MISC_SYSTEM_CONTROL_ADDR, 32'h0000_0010);
        rd(IRQ_STATUS_ADDR, 32'h0);
        btn_set <= 1'b0;
        apb(1'b1, IRQ_ENABLE_ADDR, 32'h1);
        rd(IRQ_ENABLE_ADDR, 32'h1);
        apb(1'b1, MISC_SYSTEM_CONTROL_ADDR, 32'h8);
        rd(MISC_SYSTEM_CONTROL_ADDR, 32'h0000_0008);
        btn_set <= 1'b1;
        wait3();
        check({31'h0, irq}, 32'h1);
        btn_set <= 1'b0;
        rd(IRQ_STATUS_ADDR, 32'h1);
        apb(1'b1, IRQ_CLEAR_ADDR, 32'h1);
        check({31'h0, irq}, 32'h0);
        rd(IRQ_CLEAR_ADDR, 32'h0);
        apb(1'b1, IRQ_ENABLE_ADDR, 32'h0);
        btn_set <= 1'b1;
        wait3();
        btn_set <= 1'b0;
        rd(IRQ_STATUS_ADDR, 32'h1);
        check({31'h0, irq}, 32'h0);
        apb(1'b1, IRQ_ENABLE_ADDR, 32'h1);
        check({31'h0, irq}, 32'h1);
        apb(1'b1, IRQ_CLEAR_ADDR, 32'h1);
        rd(IRQ_STATUS_ADDR, 32'h0);
        rd(32'h0100_0004, 32'h0);
        check({31'h0, e}, 32'h1);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check({24'h0, user_led}, 32'h0);
        rd(MISC_SYSTEM_CONTROL_ADDR, 32'h0);
        rd(IRQ_ENABLE_ADDR, 32'h0);
        conclude();
    end
endmodule
`default_nettype wire
